// >>> logic/trc_params.svh
// Constants for the thermometer and clock command decoder
// Function
// - Low-threshold command stores or returns two bytes
// - Memory command takes start address, then SRAM bytes
// - SRAM pointer steps per byte, wraps 1Fh to 00h
// - Config takes one byte; reads control then status
// - Start command begins one-shot or continuous conversion
// - Stop command ends continuous conversion, no data
// - Master restarts conversion after a stop
// - Master sends start per one-shot reading
// - Temperature read returns MSB first until NACK
// - Master reads one byte for coarse resolution
// - High-threshold command takes two bytes, reads back
// - Master writes threshold MSB then LSB
// - Clock command takes start address, then registers
// - Clock registers in fixed order, pointer steps
// - Seconds byte also holds the clock-run control
// - Device acknowledges every received byte
// - Direction follows the control byte read bit
// - Nonvolatile writes take about 10 ms
// - Master waits 50 ms between nonvolatile writes
// - Counter command returns one count-remaining byte
// - Slope command returns one counts-per-degree byte
// - Clock-alarm command addressed; access clears alarm flag
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH
`define TRC_CMD_CFG       8'hAC
`define TRC_CMD_MEM       8'h17
`define TRC_CMD_CONV_GO   8'hEE
`define TRC_CMD_CONV_HALT 8'h22
`define TRC_CMD_TEMP      8'hAA
`define TRC_CMD_CNT       8'hA8
`define TRC_CMD_SLOPE     8'hA9
`define TRC_CMD_HI        8'hA1
`define TRC_CMD_LO        8'hA2
`define TRC_CMD_CLK       8'hC0
`define TRC_CMD_ALM       8'hC7
`define TRC_SRAM_DEPTH    32
`define TRC_PTR_W         5
`define TRC_CLK_REGS      7
`define TRC_CLK_LAST      5'h06
`define TRC_ALM_REGS      4
`define TRC_ALM_LAST      5'h03
`define TRC_CLK_HALT_BIT  7
`define TRC_CFG_ONESHOT   0
`define TRC_CFG_RST       8'h00
`define TRC_CLK_SEC_RST   8'h80
`define TRC_THR_RST       16'h0000
`define TRC_FILL_BYTE     8'hFF
`define TRC_CLK_KHZ       40000
`define TRC_NV_WR_MS      10
`define TRC_NV_WR_CYC     (`TRC_NV_WR_MS * `TRC_CLK_KHZ)
`define TRC_HOLD_MS       50
`define TRC_HOLD_CYC      (`TRC_HOLD_MS * `TRC_CLK_KHZ)
`define TRC_CNT_W         21
`define TRC_BUF_W         10
`define TRC_BUF_DEPTH     2
`endif

// >>> logic/trc_pkg.sv
// Types shared by both ends of the command link
package trc_pkg;
  typedef enum logic [1:0] {
    TRC_K_BYTE    = 2'h0,
    TRC_K_START_W = 2'h1,
    TRC_K_START_R = 2'h2,
    TRC_K_STOP    = 2'h3
  } trc_kind_t;
  typedef enum logic [2:0] {
    TRC_D_IDLE = 3'h0,
    TRC_D_CMD  = 3'h1,
    TRC_D_ADDR = 3'h2,
    TRC_D_DATA = 3'h3,
    TRC_D_READ = 3'h4,
    TRC_D_SKIP = 3'h5
  } trc_dev_state_t;
  typedef enum logic [2:0] {
    TRC_R_BYTE      = 3'h0,
    TRC_R_START_W   = 3'h1,
    TRC_R_START_R   = 3'h2,
    TRC_R_STOP      = 3'h3,
    TRC_R_READ      = 3'h4,
    TRC_R_READ_LAST = 3'h5
  } trc_req_t;
  typedef enum logic [1:0] {
    TRC_H_IDLE = 2'h0,
    TRC_H_HOLD = 2'h1,
    TRC_H_SEND = 2'h2,
    TRC_H_READ = 2'h3
  } trc_host_state_t;
endpackage

// >>> logic/trc_if.sv
// Byte-level link between bus master end and decoder end
`timescale 1ns/1ps
interface trc_if;
  logic                m2s_valid;
  logic                m2s_ready;
  trc_pkg::trc_kind_t  m2s_kind;
  logic [7:0]          m2s_data;
  logic                s2m_valid;
  logic                s2m_ready;
  logic                s2m_nack;
  logic [7:0]          s2m_data;
  modport dev (
    input  m2s_valid, m2s_kind, m2s_data, s2m_ready, s2m_nack,
    output m2s_ready, s2m_valid, s2m_data
  );
  modport host (
    output m2s_valid, m2s_kind, m2s_data, s2m_ready, s2m_nack,
    input  m2s_ready, s2m_valid, s2m_data
  );
endinterface

// >>> logic/trc_buf.sv
// Two-entry buffer with registered full and empty
`timescale 1ns/1ps
`include "trc_params.svh"
module trc_buf (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Fill side
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  input  wire logic [`TRC_BUF_W-1:0] in_data_i,
  // Drain side
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output logic [`TRC_BUF_W-1:0]      out_data_o
);
  logic [`TRC_BUF_W-1:0] mem      [`TRC_BUF_DEPTH];
  logic [`TRC_BUF_W-1:0] next_mem [`TRC_BUF_DEPTH];
  logic       wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic       push, pop;

  always_comb begin
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  assign out_data_o = mem[rd_ptr];

  // Flags are flops so both handshake outputs come straight from registers
  always_ff @(posedge clk_i) begin
    mem <= next_mem;
    if (reset_i) begin
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      count       <= 2'h0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      in_ready_o  <= (next_count != 2'h2);
      out_valid_o <= (next_count != 2'h0);
    end
  end
endmodule

// >>> logic/trc_dev.sv
// Command decoder end: registers, SRAM and clock storage
`timescale 1ns/1ps
`include "trc_params.svh"
module trc_dev #(
  parameter int NV_WR_CYCLES = `TRC_NV_WR_CYC
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Link
  trc_if.dev                link,
  // Measurement inputs
  input  wire logic [15:0]  temp_i,
  input  wire logic [7:0]   count_remain_i,
  input  wire logic [7:0]   slope_i,
  input  wire logic         temp_alarm_flag_i,
  input  wire logic         clock_alarm_flag_i,
  // Control outputs
  output logic [7:0]        config_o,
  output logic [15:0]       high_temp_threshold_o,
  output logic [15:0]       low_temp_threshold_o,
  output logic              alarm_output_o,
  output logic              clock_halt_o,
  output logic              conv_start_o,
  output logic              conv_stop_o,
  output logic              conv_continuous_o,
  output logic              clock_alarm_clear_o,
  output logic              nv_busy_o
);
  import trc_pkg::*;

  // Named copy so the halt bit can be selected without a width cut
  localparam logic [7:0] SEC_RST = `TRC_CLK_SEC_RST;

  trc_dev_state_t          state, next_state;
  logic [7:0]              cmd, next_cmd;
  logic [1:0]              idx, next_idx;
  logic [`TRC_PTR_W-1:0]   ptr, next_ptr;
  logic [7:0]              hold_msb, next_hold_msb;
  logic [7:0]              cfg, next_cfg;
  logic [15:0]             th, next_th, tl, next_tl;
  logic [7:0]              sram      [`TRC_SRAM_DEPTH];
  logic [7:0]              next_sram [`TRC_SRAM_DEPTH];
  logic [7:0]              clk_reg       [`TRC_CLK_REGS];
  logic [7:0]              next_clk_reg  [`TRC_CLK_REGS];
  logic [7:0]              alm_reg       [`TRC_ALM_REGS];
  logic [7:0]              next_alm_reg  [`TRC_ALM_REGS];
  logic [`TRC_CNT_W-1:0]   nv_cnt, next_nv_cnt;
  logic                    s2m_valid, next_s2m_valid;
  logic [7:0]              s2m_data, next_s2m_data;
  logic                    next_conv_start, next_conv_stop, next_conv_cont, next_caf_clr;
  logic                    buf_valid, buf_ready, stall, nv_cmd, readable;
  logic [`TRC_BUF_W-1:0]   buf_data;
  trc_kind_t               head_kind;
  logic [7:0]              head_byte, rd_val, status;

  // Received events are queued so a busy decoder stalls the master, not drops bytes
  trc_buf u_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (link.m2s_valid),
    .in_ready_o  (link.m2s_ready),
    .in_data_i   ({link.m2s_kind, link.m2s_data}),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  assign head_kind = trc_kind_t'(buf_data[9:8]);
  assign head_byte = buf_data[7:0];
  assign link.s2m_valid = s2m_valid;
  assign link.s2m_data  = s2m_data;
  assign status = {temp_alarm_flag_i, clock_alarm_flag_i, nv_busy_o, conv_continuous_o, 4'h0};

  always_comb begin
    nv_cmd   = (cmd == `TRC_CMD_CFG) || (cmd == `TRC_CMD_HI) || (cmd == `TRC_CMD_LO);
    readable = nv_cmd || (cmd == `TRC_CMD_MEM) || (cmd == `TRC_CMD_TEMP) ||
               (cmd == `TRC_CMD_CNT) || (cmd == `TRC_CMD_SLOPE) ||
               (cmd == `TRC_CMD_CLK) || (cmd == `TRC_CMD_ALM);
    rd_val = `TRC_FILL_BYTE;
    case (cmd)
      `TRC_CMD_CFG:   rd_val = (idx == 2'h0) ? cfg : ((idx == 2'h1) ? status : rd_val);
      `TRC_CMD_MEM:   rd_val = sram[ptr];
      `TRC_CMD_TEMP:  rd_val = (idx == 2'h0) ? temp_i[15:8] :
                               ((idx == 2'h1) ? temp_i[7:0] : rd_val);
      `TRC_CMD_CNT:   rd_val = (idx == 2'h0) ? count_remain_i : rd_val;
      `TRC_CMD_SLOPE: rd_val = (idx == 2'h0) ? slope_i : rd_val;
      `TRC_CMD_HI:    rd_val = (idx == 2'h0) ? th[15:8] :
                               ((idx == 2'h1) ? th[7:0] : rd_val);
      `TRC_CMD_LO:    rd_val = (idx == 2'h0) ? tl[15:8] :
                               ((idx == 2'h1) ? tl[7:0] : rd_val);
      `TRC_CMD_CLK:   rd_val = (ptr <= `TRC_CLK_LAST) ? clk_reg[ptr[2:0]] : rd_val;
      `TRC_CMD_ALM:   rd_val = (ptr <= `TRC_ALM_LAST) ? alm_reg[ptr[1:0]] : rd_val;
      default:        rd_val = `TRC_FILL_BYTE;
    endcase
  end

  always_comb begin
    next_state      = state;
    next_cmd        = cmd;
    next_idx        = idx;
    next_ptr        = ptr;
    next_hold_msb   = hold_msb;
    next_cfg        = cfg;
    next_th         = th;
    next_tl         = tl;
    next_sram       = sram;
    next_clk_reg    = clk_reg;
    next_alm_reg    = alm_reg;
    next_s2m_valid  = s2m_valid;
    next_s2m_data   = s2m_data;
    next_conv_start = 1'b0;
    next_conv_stop  = 1'b0;
    next_conv_cont  = conv_continuous_o;
    next_caf_clr    = 1'b0;
    next_nv_cnt     = (nv_cnt != '0) ? nv_cnt - 1'b1 : nv_cnt;
    // Only nonvolatile data waits; other traffic flows during the write
    stall     = (state == TRC_D_DATA) && nv_busy_o && nv_cmd && (head_kind == TRC_K_BYTE);
    buf_ready = buf_valid && !stall;
    if (state == TRC_D_READ) begin
      if (s2m_valid && link.s2m_ready) begin
        next_s2m_valid = 1'b0;
        next_idx       = (idx == 2'h3) ? idx : idx + 2'h1;
        if ((cmd == `TRC_CMD_MEM) || (cmd == `TRC_CMD_CLK) || (cmd == `TRC_CMD_ALM)) begin
          next_ptr = ptr + 1'b1;
        end
        if ((cmd == `TRC_CMD_CLK) || (cmd == `TRC_CMD_ALM)) begin
          next_caf_clr = 1'b1;
        end
        if (link.s2m_nack) begin
          next_state = TRC_D_SKIP;
        end
      end else if (!s2m_valid && !buf_valid) begin
        next_s2m_valid = 1'b1;
        next_s2m_data  = rd_val;
      end
    end
    if (buf_ready) begin
      case (head_kind)
        TRC_K_STOP: begin
          next_state     = TRC_D_IDLE;
          next_s2m_valid = 1'b0;
        end
        TRC_K_START_W: begin
          next_state     = TRC_D_CMD;
          next_idx       = 2'h0;
          next_s2m_valid = 1'b0;
        end
        TRC_K_START_R: begin
          next_idx       = 2'h0;
          next_s2m_valid = 1'b0;
          next_state     = readable ? TRC_D_READ : TRC_D_SKIP;
        end
        default: begin
          if (state == TRC_D_CMD) begin
            next_cmd = head_byte;
            case (head_byte)
              `TRC_CMD_MEM, `TRC_CMD_CLK, `TRC_CMD_ALM: next_state = TRC_D_ADDR;
              `TRC_CMD_CFG, `TRC_CMD_HI, `TRC_CMD_LO:   next_state = TRC_D_DATA;
              `TRC_CMD_CONV_GO: begin
                next_conv_start = 1'b1;
                next_conv_cont  = !cfg[`TRC_CFG_ONESHOT];
                next_state      = TRC_D_SKIP;
              end
              `TRC_CMD_CONV_HALT: begin
                next_conv_stop = 1'b1;
                next_conv_cont = 1'b0;
                next_state     = TRC_D_SKIP;
              end
              default: next_state = TRC_D_SKIP;
            endcase
          end else if (state == TRC_D_ADDR) begin
            next_ptr   = head_byte[`TRC_PTR_W-1:0];
            next_state = TRC_D_DATA;
          end else if (state == TRC_D_DATA) begin
            next_idx = (idx == 2'h3) ? idx : idx + 2'h1;
            case (cmd)
              `TRC_CMD_CFG: begin
                if (idx == 2'h0) begin
                  next_cfg    = head_byte;
                  next_nv_cnt = `TRC_CNT_W'(NV_WR_CYCLES);
                end
              end
              `TRC_CMD_HI, `TRC_CMD_LO: begin
                if (idx == 2'h0) begin
                  next_hold_msb = head_byte;
                end else if (idx == 2'h1) begin
                  next_nv_cnt = `TRC_CNT_W'(NV_WR_CYCLES);
                  if (cmd == `TRC_CMD_HI) begin
                    next_th = {hold_msb, head_byte};
                  end else begin
                    next_tl = {hold_msb, head_byte};
                  end
                end
              end
              `TRC_CMD_MEM: begin
                next_sram[ptr] = head_byte;
                next_ptr       = ptr + 1'b1;
              end
              `TRC_CMD_CLK: begin
                if (ptr <= `TRC_CLK_LAST) begin
                  next_clk_reg[ptr[2:0]] = head_byte;
                end
                next_ptr     = ptr + 1'b1;
                next_caf_clr = 1'b1;
              end
              default: begin
                if (ptr <= `TRC_ALM_LAST) begin
                  next_alm_reg[ptr[1:0]] = head_byte;
                end
                next_ptr     = ptr + 1'b1;
                next_caf_clr = 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Acknowledge is the buffer handshake itself, so every byte is acked on entry
  always_ff @(posedge clk_i) begin
    sram    <= next_sram;
    alm_reg <= next_alm_reg;
    if (reset_i) begin
      state <= TRC_D_IDLE;
      cmd   <= 8'h00;
      idx   <= 2'h0;
      ptr   <= '0;
      hold_msb <= 8'h00;
      cfg   <= `TRC_CFG_RST;
      th    <= `TRC_THR_RST;
      tl    <= `TRC_THR_RST;
      nv_cnt <= '0;
      s2m_valid <= 1'b0;
      s2m_data  <= 8'h00;
      for (int i = 0; i < `TRC_CLK_REGS; i++) begin
        clk_reg[i] <= (i == 0) ? `TRC_CLK_SEC_RST : 8'h00;
      end
      config_o              <= `TRC_CFG_RST;
      high_temp_threshold_o <= `TRC_THR_RST;
      low_temp_threshold_o  <= `TRC_THR_RST;
      alarm_output_o        <= 1'b0;
      clock_halt_o          <= SEC_RST[`TRC_CLK_HALT_BIT];
      conv_start_o          <= 1'b0;
      conv_stop_o           <= 1'b0;
      conv_continuous_o     <= 1'b0;
      clock_alarm_clear_o   <= 1'b0;
      nv_busy_o             <= 1'b0;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      idx       <= next_idx;
      ptr       <= next_ptr;
      hold_msb  <= next_hold_msb;
      cfg       <= next_cfg;
      th        <= next_th;
      tl        <= next_tl;
      nv_cnt    <= next_nv_cnt;
      s2m_valid <= next_s2m_valid;
      s2m_data  <= next_s2m_data;
      clk_reg   <= next_clk_reg;
      config_o              <= next_cfg;
      high_temp_threshold_o <= next_th;
      low_temp_threshold_o  <= next_tl;
      alarm_output_o        <= ($signed(temp_i) >= $signed(th)) ||
                               ($signed(temp_i) <= $signed(tl));
      clock_halt_o          <= next_clk_reg[0][`TRC_CLK_HALT_BIT];
      conv_start_o          <= next_conv_start;
      conv_stop_o           <= next_conv_stop;
      conv_continuous_o     <= next_conv_cont;
      clock_alarm_clear_o   <= next_caf_clr;
      nv_busy_o             <= (next_nv_cnt != '0);
    end
  end
endmodule

// >>> logic/trc_host.sv
// Bus master end: issues frame events, reads bytes, spaces nonvolatile writes
`timescale 1ns/1ps
`include "trc_params.svh"
module trc_host #(
  parameter int HOLD_CYCLES = `TRC_HOLD_CYC
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  // Link
  trc_if.host                  link,
  // Request port
  input  wire logic            req_valid_i,
  input  wire trc_pkg::trc_req_t req_kind_i,
  input  wire logic [7:0]      req_data_i,
  output logic                 req_ready_o,
  // Read answer and spacing-window flag
  output logic                 rd_valid_o,
  output logic [7:0]           rd_data_o,
  output logic                 hold_o
);
  import trc_pkg::*;

  trc_host_state_t       state, next_state;
  logic [`TRC_CNT_W-1:0] hold_cnt, next_hold_cnt;
  logic                  first, next_first, nv_frame, next_nv_frame, nv_wrote, next_nv_wrote;
  logic                  m2s_valid, next_m2s_valid, s2m_ready, next_s2m_ready;
  logic                  nack, next_nack, next_rd_valid;
  trc_kind_t             kind, next_kind;
  logic [7:0]            data, next_data, next_rd_data;
  logic                  take;

  assign link.m2s_valid = m2s_valid;
  assign link.m2s_kind  = kind;
  assign link.m2s_data  = data;
  assign link.s2m_ready = s2m_ready;
  assign link.s2m_nack  = nack;

  always_comb begin
    take           = req_valid_i && req_ready_o;
    next_state     = state;
    next_hold_cnt  = (hold_cnt != '0) ? hold_cnt - 1'b1 : hold_cnt;
    next_first     = first;
    next_nv_frame  = nv_frame;
    next_nv_wrote  = nv_wrote;
    next_m2s_valid = m2s_valid;
    next_s2m_ready = s2m_ready;
    next_nack      = nack;
    next_kind      = kind;
    next_data      = data;
    next_rd_valid  = 1'b0;
    next_rd_data   = rd_data_o;
    case (state)
      TRC_H_IDLE: begin
        if (take) begin
          next_data = req_data_i;
          if ((req_kind_i == TRC_R_READ) || (req_kind_i == TRC_R_READ_LAST)) begin
            next_s2m_ready = 1'b1;
            next_nack      = (req_kind_i == TRC_R_READ_LAST);
            next_state     = TRC_H_READ;
          end else begin
            next_kind = trc_kind_t'(req_kind_i[1:0]);
            if (req_kind_i != TRC_R_BYTE) begin
              // Frame end after nonvolatile data starts the spacing window
              if (nv_wrote) begin
                next_hold_cnt = `TRC_CNT_W'(HOLD_CYCLES);
              end
              next_nv_wrote = 1'b0;
              next_first    = (req_kind_i == TRC_R_START_W);
            end else if (first) begin
              next_first    = 1'b0;
              next_nv_frame = (req_data_i == `TRC_CMD_CFG) || (req_data_i == `TRC_CMD_HI) ||
                              (req_data_i == `TRC_CMD_LO);
            end else if (nv_frame) begin
              next_nv_wrote = 1'b1;
            end
            if ((req_kind_i == TRC_R_START_W) && (next_hold_cnt != '0)) begin
              next_state = TRC_H_HOLD;
            end else begin
              next_m2s_valid = 1'b1;
              next_state     = TRC_H_SEND;
            end
          end
        end
      end
      TRC_H_HOLD: begin
        if (hold_cnt == '0) begin
          next_m2s_valid = 1'b1;
          next_state     = TRC_H_SEND;
        end
      end
      TRC_H_SEND: begin
        if (m2s_valid && link.m2s_ready) begin
          next_m2s_valid = 1'b0;
          next_state     = TRC_H_IDLE;
        end
      end
      default: begin
        if (s2m_ready && link.s2m_valid) begin
          next_s2m_ready = 1'b0;
          next_rd_valid  = 1'b1;
          next_rd_data   = link.s2m_data;
          next_state     = TRC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state       <= TRC_H_IDLE;
      hold_cnt    <= '0;
      first       <= 1'b0;
      nv_frame    <= 1'b0;
      nv_wrote    <= 1'b0;
      m2s_valid   <= 1'b0;
      s2m_ready   <= 1'b0;
      nack        <= 1'b0;
      kind        <= TRC_K_BYTE;
      data        <= 8'h00;
      req_ready_o <= 1'b1;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= 8'h00;
      hold_o      <= 1'b0;
    end else begin
      state       <= next_state;
      hold_cnt    <= next_hold_cnt;
      first       <= next_first;
      nv_frame    <= next_nv_frame;
      nv_wrote    <= next_nv_wrote;
      m2s_valid   <= next_m2s_valid;
      s2m_ready   <= next_s2m_ready;
      nack        <= next_nack;
      kind        <= next_kind;
      data        <= next_data;
      req_ready_o <= (next_state == TRC_H_IDLE);
      rd_valid_o  <= next_rd_valid;
      rd_data_o   <= next_rd_data;
      hold_o      <= (next_hold_cnt != '0);
    end
  end
endmodule

// >>> testbench/trc_props.sv
// Link protocol checker for the command link
`timescale 1ns/1ps
module trc_props (
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               reset_i,
  // Link
  input wire logic               m2s_valid,
  input wire logic               m2s_ready,
  input wire trc_pkg::trc_kind_t m2s_kind,
  input wire logic [7:0]         m2s_data,
  input wire logic               s2m_valid,
  input wire logic               s2m_ready,
  input wire logic               s2m_nack,
  input wire logic [7:0]         s2m_data
);
  import trc_pkg::*;
  logic rd_dir;
  logic next_rd_dir;
  wire  take = m2s_valid && m2s_ready;
  always_comb begin
    next_rd_dir = rd_dir;
    if (take && m2s_kind == TRC_K_START_R) next_rd_dir = 1'b1;
    if (take && m2s_kind == TRC_K_START_W) next_rd_dir = 1'b0;
  end
  always_ff @(posedge clk_i) rd_dir <= reset_i ? 1'b0 : next_rd_dir;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_req_hold: assert property (
    m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_kind) && $stable(m2s_data))
    else $error("link event changed while waiting");
  chk_byte_stand: assert property (s2m_valid && !s2m_ready |=> !s2m_valid || $stable(s2m_data))
    else $error("read byte changed while offered");
  chk_byte_drop: assert property (s2m_valid && s2m_ready |=> !s2m_valid)
    else $error("read byte not withdrawn after handshake");
  chk_reset_idle: assert property ($fell(reset_i) |-> m2s_ready && !s2m_valid)
    else $error("link not idle after reset");
  chk_ready_cause: assert property (!m2s_ready && $past(m2s_ready) |-> $past(m2s_valid))
    else $error("ready dropped with no event pushed");
  chk_ack_bound: assert property (m2s_valid |-> ##[0:100] m2s_ready)
    else $error("event never acknowledged");
  chk_read_dir: assert property ($rose(s2m_valid) |-> rd_dir)
    else $error("read byte offered in a write frame");
  chk_stop_end: assert property (take && m2s_kind == TRC_K_STOP |-> ##[0:4] !s2m_valid)
    else $error("read byte still offered after stop");
endmodule

// >>> testbench/tb.sv
// Self-checking bench joining both ends of the command link
`timescale 1ns/1ps
module tb;
  import trc_pkg::*;
  logic clk_i, reset_i, vld, temp_alarm_flag, caf, rdy, halt, clr, go, stp, alm, cont, nvb, hld, rv;
  trc_req_t kind;
  logic [7:0] dat, rdat, rdo, cnt, slp, cfgv, cfg;
  logic [15:0] temp, thi, tlo;
  logic [31:0] seed, r, d;
  int error_cnt, checks_done, n_go, n_stp, n_clr, n_nv, n_rv, g;
  trc_if lk();
  trc_dev #(.NV_WR_CYCLES(20)) trc_dev_inst (.clk_i(clk_i), .reset_i(reset_i), .link(lk.dev),
    .temp_i(temp), .count_remain_i(cnt), .slope_i(slp), .temp_alarm_flag_i(temp_alarm_flag),
    .clock_alarm_flag_i(caf), .config_o(cfg), .high_temp_threshold_o(thi),
    .low_temp_threshold_o(tlo), .alarm_output_o(alm), .clock_halt_o(halt), .conv_start_o(go),
    .conv_stop_o(stp), .conv_continuous_o(cont), .clock_alarm_clear_o(clr), .nv_busy_o(nvb));
  trc_host #(.HOLD_CYCLES(30)) trc_host_inst (.clk_i(clk_i), .reset_i(reset_i), .link(lk.host),
    .req_valid_i(vld), .req_kind_i(kind), .req_data_i(dat), .req_ready_o(rdy),
    .rd_valid_o(rv), .rd_data_o(rdo), .hold_o(hld));
  trc_props trc_props_inst (.clk_i(clk_i), .reset_i(reset_i), .m2s_valid(lk.m2s_valid),
    .m2s_ready(lk.m2s_ready), .m2s_kind(lk.m2s_kind), .m2s_data(lk.m2s_data),
    .s2m_valid(lk.s2m_valid), .s2m_ready(lk.s2m_ready), .s2m_nack(lk.s2m_nack),
    .s2m_data(lk.s2m_data));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Pulse outputs are counted, since they stand for one cycle only; nvb is counted per busy cycle
  always @(posedge clk_i) begin
    n_go += go;
    n_stp += stp;
    n_clr += clr;
    n_nv += nvb;
    n_rv += rv;
  end
  function automatic logic [7:0] stat(logic t, logic c);
    return {t, c, 6'h00};
  endfunction
  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until taken, then waits for the master end to be free
  task automatic rq(trc_req_t k, logic [7:0] v);
    int n;
    n = 0;
    @(negedge clk_i);
    vld = 1'b1;
    kind = k;
    dat = v;
    while (!rdy && n < 300) begin @(negedge clk_i); n++; end
    @(negedge clk_i);
    vld = 1'b0;
    while (!rdy && n < 300) begin @(negedge clk_i); n++; end
    if (n >= 300) begin error_cnt++; finish_test(); end
    rdat = rdo;
  endtask
  task automatic wr(logic [7:0] c, int n, logic [31:0] v);
    rq(TRC_R_START_W, 8'h00);
    rq(TRC_R_BYTE, c);
    for (int i = 0; i < n; i++) rq(TRC_R_BYTE, v[31-8*i -: 8]);
    rq(TRC_R_STOP, 8'h00);
  endtask
  task automatic rd(logic [7:0] c, int na, logic [7:0] a, int n);
    rq(TRC_R_START_W, 8'h00);
    rq(TRC_R_BYTE, c);
    if (na > 0) rq(TRC_R_BYTE, a);
    rq(TRC_R_START_R, 8'h00);
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      rq(i == n - 1 ? TRC_R_READ_LAST : TRC_R_READ, 8'h00);
      r = {r[23:0], rdat};
    end
    rq(TRC_R_STOP, 8'h00);
  endtask
  initial begin
    seed = 32'h309f10fb;
    {vld, dat, error_cnt, checks_done} = '0;
    kind = TRC_R_BYTE;
    {temp, cnt, slp} = $random(seed);
    {temp_alarm_flag, caf} = 2'($random(seed));
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    chk(halt, 1'b1);
    // Two extra bytes stall behind the busy write and fill the buffer
    wr(8'hA1, 4, 32'h3200_AA55);
    chk(thi, 16'h3200);
    chk(hld, 1'b1);
    d = $random(seed);
    wr(8'hA2, 2, d);
    chk(tlo, d[31:16]);
    rd(8'hA2, 0, 8'h00, 2);
    chk(r, d[31:16]);
    chk(alm, ($signed(temp) >= 16'sh3200) || ($signed(temp) <= $signed(d[31:16])));
    cfgv = 8'($random(seed)) | 8'h01;
    wr(8'hAC, 1, {cfgv, 24'h0});
    chk(cfg, cfgv);
    rd(8'hAC, 0, 8'h00, 2);
    chk(r, {cfgv, stat(temp_alarm_flag, caf)});
    rd(8'hAA, 0, 8'h00, 2);
    chk(r, temp);
    rd(8'hA8, 0, 8'h00, 1);
    chk(r, cnt);
    rd(8'hA9, 0, 8'h00, 1);
    chk(r, slp);
    d = $random(seed);
    wr(8'h17, 4, {8'h1F, d[23:0]});
    rd(8'h17, 1, 8'h1F, 2);
    chk(r, d[23:8]);
    rd(8'h17, 1, 8'h00, 2);
    chk(r, d[15:0]);
    g = n_clr;
    wr(8'hC0, 3, {8'h00, 8'h00, d[7:0], 8'h0});
    chk(halt, 1'b0);
    rd(8'hC0, 1, 8'h01, 1);
    chk(r, d[7:0]);
    chk(n_clr, g + 3);
    wr(8'hC7, 2, {8'h02, d[15:8], 16'h0});
    rd(8'hC7, 1, 8'h02, 1);
    chk(r, d[15:8]);
    g = n_go;
    wr(8'hEE, 0, 32'h0);
    chk(n_go, g + 1);
    chk(cont, 1'b0);
    wr(8'h22, 0, 32'h0);
    chk(n_stp, 1);
    wr(8'h5A, 1, 32'h0);
    chk({cfg, n_go[7:0], n_stp[7:0]}, {cfgv, g[7:0] + 8'h01, 8'h01});
    wr(8'hAC, 1, 32'h0);
    wr(8'hEE, 0, 32'h0);
    chk(cont, 1'b1);
    wr(8'h22, 0, 32'h0);
    chk(cont, 1'b0);
    chk(n_nv, 4 * 20);
    chk(n_rv, 14);
    finish_test();
  end
endmodule
